/* design/apc_pkg.sv */
// shared constants and carriers for the audio path configuration registers
package apc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_LOOPBACK = 8'h08;
  localparam logic [7:0] OFS_GAIN     = 8'h09;
  localparam logic [7:0] OFS_IMPED    = 8'h0A;
  localparam logic [7:0] OFS_HYBRID   = 8'h0B;

  // values after reset
  localparam logic [7:0] RST_LOOPBACK = 8'h00;
  localparam logic [7:0] RST_GAIN     = 8'h00;
  localparam logic [7:0] RST_IMPED    = 8'h00;
  localparam logic [7:0] RST_HYBRID   = 8'h33;

  // writable bits; everything else is reserved
  localparam logic [7:0] MASK_LOOPBACK = 8'h07;
  localparam logic [7:0] MASK_GAIN     = 8'hFF;
  localparam logic [7:0] MASK_IMPED    = 8'h3F;
  localparam logic [7:0] MASK_HYBRID   = 8'h77;

  // loopback control fields
  localparam int POS_FULL_LOOP    = 2;
  localparam int POS_DIGITAL_LOOP = 1;
  localparam int POS_PART_LOOP    = 0;

  // audio gain control fields
  localparam int POS_RX_HP_BYP = 7;
  localparam int POS_TX_HP_BYP = 6;
  localparam int POS_TX_MUTE   = 5;
  localparam int POS_RX_MUTE   = 4;
  localparam int POS_TX_GAIN   = 2;
  localparam int POS_RX_GAIN   = 0;

  // line impedance control fields
  localparam int POS_CAP_COMP  = 4;
  localparam int POS_SYNTH_EN  = 3;
  localparam int POS_NETWORK   = 0;

  // hybrid balance control fields
  localparam int POS_METER_HYB = 4;
  localparam int POS_AUDIO_HYB = 0;

  // analog gain codes
  localparam logic [1:0] GAIN_0DB   = 2'h0;
  localparam logic [1:0] GAIN_CUT   = 2'h1;
  localparam logic [1:0] GAIN_BOOST = 2'h2;
  localparam logic [1:0] GAIN_MUTE  = 2'h3;

  // line capacitance compensation codes
  localparam logic [1:0] CAP_OFF  = 2'h0;
  localparam logic [1:0] CAP_4N7  = 2'h1;
  localparam logic [1:0] CAP_10N  = 2'h2;

  // hybrid codes
  localparam logic [2:0] HYB_0DB = 3'h3;
  localparam logic [2:0] HYB_OFF = 3'h7;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apc_bus_req_s;

  typedef struct packed {
    logic       full_analog_loop_en;
    logic       digital_loop_en;
    logic       partial_analog_loop_en;
    logic       rx_highpass_bypass;
    logic       tx_highpass_bypass;
    logic       tx_digital_mute;
    logic       rx_digital_mute;
    logic [1:0] tx_analog_gain_sel;
    logic [1:0] rx_analog_gain_sel;
    logic [1:0] line_cap_comp_sel;
    logic       impedance_synth_en;
    logic [2:0] impedance_network_sel;
    logic [2:0] metering_hybrid_sel;
    logic [2:0] audio_hybrid_sel;
  } apc_ctrl_s;

  typedef struct packed {
    logic       tx_gain_cut;
    logic       tx_gain_boost;
    logic       tx_analog_mute;
    logic       rx_gain_cut;
    logic       rx_gain_boost;
    logic       rx_analog_mute;
    logic       cap_comp_4n7;
    logic       cap_comp_10n;
    logic [7:0] network_onehot;
    logic       metering_hybrid_off;
    logic       audio_hybrid_off;
  } apc_decode_s;

endpackage : apc_pkg

/* design/apc_regs.sv */
// audio path configuration register bank with decoded path controls
`timescale 1ns/1ps

module apc_regs (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire apc_pkg::apc_bus_req_s bus_req,
  output logic [apc_pkg::DATA_W-1:0] rdata,
  output apc_pkg::apc_ctrl_s         ctrl,
  output apc_pkg::apc_decode_s       decode
);

  logic [7:0] loop_reg;
  logic [7:0] gain_reg;
  logic [7:0] imped_reg;
  logic [7:0] hyb_reg;
  logic [7:0] loop_next;
  logic [7:0] gain_next;
  logic [7:0] imped_next;
  logic [7:0] hyb_next;
  logic       hit_loop;
  logic       hit_gain;
  logic       hit_imped;
  logic       hit_hyb;

  assign hit_loop  = bus_req.addr == apc_pkg::OFS_LOOPBACK;
  assign hit_gain  = bus_req.addr == apc_pkg::OFS_GAIN;
  assign hit_imped = bus_req.addr == apc_pkg::OFS_IMPED;
  assign hit_hyb   = bus_req.addr == apc_pkg::OFS_HYBRID;

  // next values with reserved bits forced to zero
  always_comb begin
    loop_next  = loop_reg;
    gain_next  = gain_reg;
    imped_next = imped_reg;
    hyb_next   = hyb_reg;
    if (bus_req.wr) begin
      if (hit_loop) begin
        loop_next = bus_req.wdata & apc_pkg::MASK_LOOPBACK;
      end
      if (hit_gain) begin
        gain_next = bus_req.wdata & apc_pkg::MASK_GAIN;
      end
      if (hit_imped) begin
        imped_next = bus_req.wdata & apc_pkg::MASK_IMPED;
      end
      if (hit_hyb) begin
        hyb_next = bus_req.wdata & apc_pkg::MASK_HYBRID;
      end
    end
  end

  // storage; writes have no effect beyond the stored value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loop_reg  <= apc_pkg::RST_LOOPBACK;
      gain_reg  <= apc_pkg::RST_GAIN;
      imped_reg <= apc_pkg::RST_IMPED;
      hyb_reg   <= apc_pkg::RST_HYBRID;
    end else begin
      loop_reg  <= loop_next;
      gain_reg  <= gain_next;
      imped_reg <= imped_next;
      hyb_reg   <= hyb_next;
    end
  end

  // read data stands only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        apc_pkg::OFS_LOOPBACK: rdata <= loop_reg;
        apc_pkg::OFS_GAIN:     rdata <= gain_reg;
        apc_pkg::OFS_IMPED:    rdata <= imped_reg;
        apc_pkg::OFS_HYBRID:   rdata <= hyb_reg;
        default:               rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // raw field outputs, loaded from next values so they track the registers exactly
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= '0;
      ctrl.metering_hybrid_sel <= apc_pkg::HYB_0DB;
      ctrl.audio_hybrid_sel    <= apc_pkg::HYB_0DB;
    end else begin
      ctrl.full_analog_loop_en    <= loop_next[apc_pkg::POS_FULL_LOOP];
      ctrl.digital_loop_en        <= loop_next[apc_pkg::POS_DIGITAL_LOOP];
      ctrl.partial_analog_loop_en <= loop_next[apc_pkg::POS_PART_LOOP];
      ctrl.rx_highpass_bypass     <= gain_next[apc_pkg::POS_RX_HP_BYP];
      ctrl.tx_highpass_bypass     <= gain_next[apc_pkg::POS_TX_HP_BYP];
      ctrl.tx_digital_mute        <= gain_next[apc_pkg::POS_TX_MUTE];
      ctrl.rx_digital_mute        <= gain_next[apc_pkg::POS_RX_MUTE];
      ctrl.tx_analog_gain_sel     <= gain_next[apc_pkg::POS_TX_GAIN +: 2];
      ctrl.rx_analog_gain_sel     <= gain_next[apc_pkg::POS_RX_GAIN +: 2];
      ctrl.line_cap_comp_sel      <= imped_next[apc_pkg::POS_CAP_COMP +: 2];
      ctrl.impedance_synth_en     <= imped_next[apc_pkg::POS_SYNTH_EN];
      ctrl.impedance_network_sel  <= imped_next[apc_pkg::POS_NETWORK +: 3];
      ctrl.metering_hybrid_sel    <= hyb_next[apc_pkg::POS_METER_HYB +: 3];
      ctrl.audio_hybrid_sel       <= hyb_next[apc_pkg::POS_AUDIO_HYB +: 3];
    end
  end

  // gain and mute decode for the analog path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      decode.tx_gain_cut    <= 1'b0;
      decode.tx_gain_boost  <= 1'b0;
      decode.tx_analog_mute <= 1'b0;
      decode.rx_gain_cut    <= 1'b0;
      decode.rx_gain_boost  <= 1'b0;
      decode.rx_analog_mute <= 1'b0;
    end else begin
      // code 11 keeps 0 dB gain while muting, so neither cut nor boost
      decode.tx_gain_cut    <= gain_next[apc_pkg::POS_TX_GAIN +: 2] == apc_pkg::GAIN_CUT;
      decode.tx_gain_boost  <= gain_next[apc_pkg::POS_TX_GAIN +: 2] == apc_pkg::GAIN_BOOST;
      decode.tx_analog_mute <= gain_next[apc_pkg::POS_TX_GAIN +: 2] == apc_pkg::GAIN_MUTE;
      decode.rx_gain_cut    <= gain_next[apc_pkg::POS_RX_GAIN +: 2] == apc_pkg::GAIN_CUT;
      decode.rx_gain_boost  <= gain_next[apc_pkg::POS_RX_GAIN +: 2] == apc_pkg::GAIN_BOOST;
      decode.rx_analog_mute <= gain_next[apc_pkg::POS_RX_GAIN +: 2] == apc_pkg::GAIN_MUTE;
    end
  end

  // line compensation and termination network decode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      decode.cap_comp_4n7   <= 1'b0;
      decode.cap_comp_10n   <= 1'b0;
      decode.network_onehot <= 8'h00;
    end else begin
      // reserved code 11 engages neither capacitor, the safe choice
      decode.cap_comp_4n7 <= imped_next[apc_pkg::POS_CAP_COMP +: 2] == apc_pkg::CAP_4N7;
      decode.cap_comp_10n <= imped_next[apc_pkg::POS_CAP_COMP +: 2] == apc_pkg::CAP_10N;
      // no network engaged while synthesis is off
      if (imped_next[apc_pkg::POS_SYNTH_EN]) begin
        decode.network_onehot <= 8'h01 << imped_next[apc_pkg::POS_NETWORK +: 3];
      end else begin
        decode.network_onehot <= 8'h00;
      end
    end
  end

  // hybrid off decode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      decode.metering_hybrid_off <= 1'b0;
      decode.audio_hybrid_off    <= 1'b0;
    end else begin
      decode.metering_hybrid_off <= hyb_next[apc_pkg::POS_METER_HYB +: 3] == apc_pkg::HYB_OFF;
      decode.audio_hybrid_off    <= hyb_next[apc_pkg::POS_AUDIO_HYB +: 3] == apc_pkg::HYB_OFF;
    end
  end

endmodule : apc_regs

/* sim/apc_regs_properties.sv */
// port-level checks for the audio path configuration registers
`timescale 1ns/1ps
module apc_regs_properties (
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire apc_pkg::apc_bus_req_s bus_req,
  input wire logic [apc_pkg::DATA_W-1:0] rdata,
  input wire apc_pkg::apc_ctrl_s    ctrl,
  input wire apc_pkg::apc_decode_s  decode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_read_idle_zero: assert property (
    !$past(bus_req.rd) |-> rdata == 8'h00) else $error("rdata not zero when idle");
  a_loop_readback: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 8'h08 |->
    rdata == {5'h00, ctrl.full_analog_loop_en, ctrl.digital_loop_en,
    ctrl.partial_analog_loop_en}) else $error("loopback readback wrong");
  a_gain_readback: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 8'h09 |->
    rdata == {ctrl.rx_highpass_bypass, ctrl.tx_highpass_bypass, ctrl.tx_digital_mute,
    ctrl.rx_digital_mute, ctrl.tx_analog_gain_sel, ctrl.rx_analog_gain_sel})
    else $error("gain readback wrong");
  a_imped_readback: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 8'h0A |->
    rdata == {2'h0, ctrl.line_cap_comp_sel, ctrl.impedance_synth_en,
    ctrl.impedance_network_sel}) else $error("impedance readback wrong");
  a_hybrid_readback: assert property ($past(bus_req.rd) && $past(bus_req.addr) == 8'h0B |->
    rdata == {1'b0, ctrl.metering_hybrid_sel, 1'b0, ctrl.audio_hybrid_sel})
    else $error("hybrid readback wrong");
  a_gain_write: assert property (bus_req.wr && bus_req.addr == 8'h09 |=>
    {ctrl.rx_highpass_bypass, ctrl.tx_highpass_bypass, ctrl.tx_digital_mute, ctrl.rx_digital_mute,
    ctrl.tx_analog_gain_sel, ctrl.rx_analog_gain_sel} == $past(bus_req.wdata))
    else $error("gain write not applied");
  a_tx_gain_decode: assert property ({decode.tx_gain_cut, decode.tx_gain_boost,
    decode.tx_analog_mute} == {ctrl.tx_analog_gain_sel == 2'h1, ctrl.tx_analog_gain_sel == 2'h2,
    ctrl.tx_analog_gain_sel == 2'h3}) else $error("transmit gain decode wrong");
  a_network_decode: assert property (decode.network_onehot ==
    (ctrl.impedance_synth_en ? 8'h01 << ctrl.impedance_network_sel : 8'h00))
    else $error("network decode wrong");
  a_unmapped_read: assert property ($past(bus_req.rd) &&
    ($past(bus_req.addr) < 8'h08 || $past(bus_req.addr) > 8'h0B) |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (bus_req.wr && bus_req.addr == 8'h0B);
  cover property (decode.audio_hybrid_off && decode.metering_hybrid_off);
  cover property (decode.rx_analog_mute && ctrl.impedance_synth_en);
endmodule : apc_regs_properties
bind apc_regs apc_regs_properties chk (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
  .rdata(rdata), .ctrl(ctrl), .decode(decode));

/* sim/apc_regs_bench.sv */
// self-checking bench for the audio path configuration registers
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module apc_regs_bench;
  localparam logic [7:0] MSK [8:11] = '{8'h07, 8'hFF, 8'h3F, 8'h77};
  logic                  clk;
  logic                  rst_b;
  apc_pkg::apc_bus_req_s bus_req;
  logic [7:0]            rdata;
  apc_pkg::apc_ctrl_s    ctrl;
  apc_pkg::apc_decode_s  decode;
  int                    n_fail;
  int                    n_checks;
  int                    seed;
  logic [7:0]            m [8:11];
  apc_regs uut (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata), .ctrl(ctrl),
    .decode(decode));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize;
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic model_reset;
    m[8] = 8'h00;
    m[9] = 8'h00;
    m[10] = 8'h00;
    m[11] = 8'h33;
  endtask : model_reset
  function automatic logic [17:0] dec_exp();
    logic [1:0] t;
    logic [1:0] r;
    logic [1:0] c;
    t = m[9][3:2];
    r = m[9][1:0];
    c = m[10][5:4];
    return {t == 2'h1, t == 2'h2, t == 2'h3, r == 2'h1, r == 2'h2, r == 2'h3, c == 2'h1,
      c == 2'h2, m[10][3] ? 8'h01 << m[10][2:0] : 8'h00, m[11][6:4] == 3'h7, m[11][2:0] == 3'h7};
  endfunction : dec_exp
  task automatic check_out;
    logic [22:0] e;
    e = {m[8][2:0], m[9], m[10][5:0], m[11][6:4], m[11][2:0]};
    `CHK("ctrl", e, ctrl)
    `CHK("decode", dec_exp(), decode)
  endtask : check_out
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    // reserved bits drop out of the model
    if (a >= 8'h08 && a <= 8'h0B) m[a] = d & MSK[a];
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = (a >= 8'h08 && a <= 8'h0B) ? m[a] : 8'h00;
    @(posedge clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd
  initial begin
    logic [7:0] a;
    seed = 46305;
    n_fail = 0;
    n_checks = 0;
    rst_b = 1'b0;
    bus_req = '0;
    model_reset();
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 6; k < 14; k++) rd(k[7:0]);
    check_out();
    for (int i = 0; i < 300; i++) begin
      a = 8'h06 + {5'h00, 3'($random(seed))};
      wr(a, 8'($random(seed)));
      #1 check_out();
      rd(a);
    end
    // reset in mid-run must restore every field
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    model_reset();
    #1 check_out();
    for (int k = 8; k < 12; k++) rd(k[7:0]);
    summarize();
  end
  initial begin
    #50000;
    n_fail++;
    summarize();
  end
endmodule : apc_regs_bench
